/* File: verilog/framer_defines.svh */
// Constants of the superframe framer: frame layout, patterns and slot limits.
// Assumes a 40 MHz system clock and a bus bit clock that arrives on a pin.
`ifndef FRAMER_DEFINES_SVH
`define FRAMER_DEFINES_SVH

`define BITS_PER_FRAME  11'h400
`define BIT_CNT_MAX     11'h7FF
`define PRE_PATTERN     16'hF0C5
`define SCF_LAST        10'h03F
`define SRF_LAST        10'h01F
`define MAX_SLOTS_W24   6'h20
`define MAX_SLOTS_W16   6'h33
`define SLOT_LAST_W24   5'h17
`define SLOT_LAST_W16   5'h0F

`endif

/* File: verilog/framer_pkg.sv */
// Types shared by the superframe framer: phases, frame payloads, settings, state.
// Assumes framer_defines.svh supplies the numeric constants.
package framer_pkg;

  typedef enum logic [2:0] {PH_IDLE, PH_SCF, PH_DN, PH_WAIT, PH_SRF, PH_UP} phase_t;

  typedef enum logic [1:0] {XFER_NONE, XFER_I2C, XFER_SPI, XFER_IRQ_ACK} xfer_t;

  // Control payload of the sync_control_frame, 48 bits
  typedef struct packed {
    logic [3:0]  node;
    xfer_t       kind;
    logic        rd;
    logic        bcast;
    logic [7:0]  addr;
    logic [7:0]  data;
    logic [7:0]  gpio;
    logic [15:0] spi;
  } ctl_t;

  // Payload of the sync_response_frame, 16 bits after the preamble
  typedef struct packed {
    logic [3:0] node;
    logic       irq;
    logic       ack;
    logic [1:0] rsvd;
    logic [7:0] data;
  } resp_t;

  typedef struct packed {
    logic       wide;
    logic [5:0] n_dn;
    logic [5:0] n_up;
    logic [9:0] resp_wait;
  } cfg_t;

  typedef struct packed {
    logic        sync_m, sync_s, sync_p;
    logic        bclk_m, bclk_s, bclk_p;
    logic        rx_m, rx_s;
    phase_t      phase;
    logic [9:0]  pcnt;
    logic [4:0]  sub;
    logic [5:0]  slot;
    logic [10:0] bit_cnt;
    logic        lock;
    logic        bank;
    cfg_t        cfg;
    ctl_t        ctl;
    logic        cur_bit;
    logic        tx_lvl;
    logic        oe;
    logic        rx_rise_lvl;
    logic        rx_fall_lvl;
    logic [31:0] rx_sh;
    resp_t       resp;
    logic        resp_ok;
    logic        resp_stb;
    logic [5:0]  up_got;
    logic [5:0]  up_prev;
    logic [5:0]  drain;
    logic [5:0]  wr_idx;
    logic        dn_rdy;
    logic [7:0]  dly_cnt;
    logic        dly_arm;
    logic        sync_out;
  } state_t;

endpackage

/* File: verilog/framer_buf.sv */
// Small shift-register FIFO with valid/ready on both sides.
// Assumes one clock; head entry and flags are flops so outputs need no logic.
`timescale 1ns/1ps
module framer_buf #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 2
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [CW-1:0]               cnt;
    logic                        vld;
    logic                        rdy;
  } buf_state_t;

  buf_state_t s_q;
  buf_state_t s_d;

  // Entries slide toward slot 0 so the head is always a plain flop
  always_comb
  begin
    logic [CW-1:0] n;
    n = s_q.cnt;
    s_d = s_q;
    if (s_q.vld && i_out_ready)
    begin
      for (int i = 0; i < DEPTH - 1; i++)
        s_d.mem[i] = s_q.mem[i + 1];
      n = n - CW'(1);
    end
    if (i_in_valid && s_q.rdy)
    begin
      s_d.mem[n] = i_in_data;
      n = n + CW'(1);
    end
    s_d.cnt = n;
    s_d.vld = (n != '0);
    s_d.rdy = (n != CW'(DEPTH)); // Honest full: stalls the source
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      s_q     <= '0;
      s_q.rdy <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  assign o_in_ready  = s_q.rdy;
  assign o_out_valid = s_q.vld;
  assign o_out_data  = s_q.mem[0];
endmodule

/* File: verilog/superframe_framer.sv */
// Main node superframe framer: sends control frame and downstream slots,
// receives response frame and upstream slots, delays the local sync output.
// Assumes host sync, bus bit clock and bus line arrive from outside the clock domain.
`timescale 1ns/1ps
`include "framer_defines.svh"
module superframe_framer (
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  input  wire logic              i_sync,
  input  wire logic              i_bit_clk,
  input  wire logic              i_bus_rx,
  output logic                   o_bus_tx,
  output logic                   o_bus_oe,
  input  wire framer_pkg::cfg_t  i_cfg,
  input  wire framer_pkg::ctl_t  i_ctl,
  input  wire logic [7:0]        i_sync_dly,
  output logic                   o_sync_out,
  output logic                   o_lock,
  output framer_pkg::resp_t      o_resp,
  output logic                   o_resp_ok,
  output logic                   o_resp_valid,
  input  wire logic              i_dn_valid,
  input  wire logic [23:0]       i_dn_data,
  output logic                   o_dn_ready,
  output logic                   o_up_valid,
  input  wire logic              i_up_ready,
  output logic [23:0]            o_up_data
);
  framer_pkg::state_t s_q;
  framer_pkg::state_t s_d;

  logic [23:0] dn_mem [0:127];
  logic [23:0] up_mem [0:127];
  logic        dn_we;
  logic        up_we;
  logic [23:0] up_wdata;
  logic        push;
  logic        buf_rdy;
  logic [23:0] up_rdata;
  logic        sync_edge;
  logic        rise;
  logic        fall;
  logic        rx_bit;
  logic [31:0] sh_next;
  logic [63:0] scf_word;
  logic [23:0] dn_word;

  // Last bit index of a slot for the configured width
  function automatic logic [4:0] slot_last(input logic wide);
    return wide ? `SLOT_LAST_W24 : `SLOT_LAST_W16;
  endfunction

  // Slot count clamped to what the width allows
  function automatic logic [5:0] slot_lim(input logic [5:0] n, input logic wide);
    logic [5:0] m;
    m = wide ? `MAX_SLOTS_W24 : `MAX_SLOTS_W16;
    return (n > m) ? m : n;
  endfunction

  // Edges seen only on the second synchroniser stage
  assign sync_edge = s_q.sync_s & ~s_q.sync_p;
  assign rise      = s_q.bclk_s & ~s_q.bclk_p;
  assign fall      = ~s_q.bclk_s & s_q.bclk_p;
  assign rx_bit    = s_q.rx_fall_lvl ^ s_q.rx_rise_lvl;
  assign sh_next   = {s_q.rx_sh[30:0], rx_bit};
  assign scf_word  = {`PRE_PATTERN, s_q.ctl};
  assign dn_word   = dn_mem[{~s_q.bank, s_q.slot}];
  assign up_rdata  = up_mem[{~s_q.bank, s_q.drain}];

  // Whole framer state advances here
  always_comb
  begin
    s_d        = s_q;
    dn_we      = 1'b0;
    up_we      = 1'b0;
    up_wdata   = 24'h000000;
    push       = 1'b0;
    s_d.sync_m = i_sync;
    s_d.sync_s = s_q.sync_m;
    s_d.sync_p = s_q.sync_s;
    s_d.bclk_m = i_bit_clk;
    s_d.bclk_s = s_q.bclk_m;
    s_d.bclk_p = s_q.bclk_s;
    s_d.rx_m   = i_bus_rx;
    s_d.rx_s   = s_q.rx_m;
    s_d.resp_stb = 1'b0;
    s_d.sync_out = 1'b0;

    // Port samples land in the bank that goes out next superframe
    if (s_q.dn_rdy && i_dn_valid)
    begin
      dn_we      = 1'b1;
      s_d.wr_idx = s_q.wr_idx + 6'h01;
    end

    // Last superframe's upstream words drain to the port now
    if ((s_q.drain != s_q.up_prev) && buf_rdy)
    begin
      push      = 1'b1;
      s_d.drain = s_q.drain + 6'h01;
    end

    // Fine delay of the local sync output, in system clocks
    if (s_q.dly_arm)
    begin
      if (s_q.dly_cnt == 8'h00)
      begin
        s_d.sync_out = 1'b1;
        s_d.dly_arm  = 1'b0;
      end
      else
        s_d.dly_cnt = s_q.dly_cnt - 8'h01;
    end

    if (sync_edge)
    begin
      // New superframe; a bit clock edge in the same cycle is dropped
      s_d.lock    = (s_q.bit_cnt == `BITS_PER_FRAME);
      s_d.bit_cnt = 11'h000;
      s_d.bank    = ~s_q.bank;
      s_d.cfg     = i_cfg;
      s_d.ctl     = i_ctl;
      s_d.phase   = framer_pkg::PH_SCF;
      s_d.pcnt    = 10'h000;
      s_d.sub     = 5'h00;
      s_d.slot    = 6'h00;
      s_d.oe      = 1'b0;
      s_d.wr_idx  = 6'h00;
      s_d.drain   = 6'h00;
      s_d.up_prev = s_q.up_got;
      s_d.up_got  = 6'h00;
      s_d.dly_cnt = i_sync_dly;
      s_d.dly_arm = 1'b1;
    end
    else if (rise)
    begin
      if (s_q.bit_cnt != `BIT_CNT_MAX)
        s_d.bit_cnt = s_q.bit_cnt + 11'h001;
      s_d.rx_rise_lvl = s_q.rx_s;
      case (s_q.phase)
        framer_pkg::PH_SCF:
        begin
          // Preamble then control payload, back to back
          s_d.cur_bit = scf_word[~s_q.pcnt[5:0]];
          s_d.tx_lvl  = ~s_q.tx_lvl;
          s_d.oe      = 1'b1;
          s_d.pcnt    = s_q.pcnt + 10'h001;
          if (s_q.pcnt == `SCF_LAST)
          begin
            s_d.pcnt  = 10'h000;
            s_d.phase = (slot_lim(s_q.cfg.n_dn, s_q.cfg.wide) != 6'h00) ?
                        framer_pkg::PH_DN : framer_pkg::PH_WAIT;
          end
        end
        framer_pkg::PH_DN:
        begin
          // All downstream slots leave in this one superframe
          s_d.cur_bit = dn_word[slot_last(s_q.cfg.wide) - s_q.sub];
          s_d.tx_lvl  = ~s_q.tx_lvl;
          s_d.oe      = 1'b1;
          if (s_q.sub == slot_last(s_q.cfg.wide))
          begin
            s_d.sub  = 5'h00;
            s_d.slot = s_q.slot + 6'h01;
            if (s_q.slot == slot_lim(s_q.cfg.n_dn, s_q.cfg.wide) - 6'h01)
            begin
              s_d.slot  = 6'h00;
              s_d.pcnt  = 10'h000;
              s_d.phase = framer_pkg::PH_WAIT;
            end
          end
          else
            s_d.sub = s_q.sub + 5'h01;
        end
        framer_pkg::PH_WAIT:
        begin
          // Line released; last node answers after the response wait
          s_d.oe   = 1'b0;
          s_d.pcnt = s_q.pcnt + 10'h001;
          if (s_q.pcnt == s_q.cfg.resp_wait)
          begin
            s_d.pcnt  = 10'h000;
            s_d.phase = framer_pkg::PH_SRF;
          end
        end
        framer_pkg::PH_SRF:
        begin
          // Each decoded bit belongs to the period that just ended
          s_d.rx_sh = sh_next;
          s_d.pcnt  = s_q.pcnt + 10'h001;
          if (s_q.pcnt == `SRF_LAST)
          begin
            s_d.pcnt     = 10'h000;
            s_d.resp     = sh_next[15:0];
            s_d.resp_ok  = (sh_next[31:16] == `PRE_PATTERN);
            s_d.resp_stb = 1'b1;
            s_d.phase    = ((sh_next[31:16] == `PRE_PATTERN) &&
                            (slot_lim(s_q.cfg.n_up, s_q.cfg.wide) != 6'h00)) ?
                           framer_pkg::PH_UP : framer_pkg::PH_IDLE;
          end
        end
        framer_pkg::PH_UP:
        begin
          // Slots from any node are taken as they come, none relayed
          s_d.rx_sh = sh_next;
          if (s_q.sub == slot_last(s_q.cfg.wide))
          begin
            up_we      = 1'b1;
            up_wdata   = s_q.cfg.wide ? sh_next[23:0] : {8'h00, sh_next[15:0]};
            s_d.up_got = s_q.slot + 6'h01;
            s_d.sub    = 5'h00;
            s_d.slot   = s_q.slot + 6'h01;
            if (s_q.slot == slot_lim(s_q.cfg.n_up, s_q.cfg.wide) - 6'h01)
              s_d.phase = framer_pkg::PH_IDLE;
          end
          else
            s_d.sub = s_q.sub + 5'h01;
        end
        default:
          s_d.oe = 1'b0;
      endcase
    end
    else if (fall)
    begin
      // Biphase mark: a one toggles the line again mid bit
      s_d.rx_fall_lvl = s_q.rx_s;
      if (s_q.oe && s_q.cur_bit)
        s_d.tx_lvl = ~s_q.tx_lvl;
    end

    // Room only for the clamped number of downstream slots
    s_d.dn_rdy = (s_d.wr_idx < slot_lim(s_d.cfg.n_dn, s_d.cfg.wide));
  end

  // State register; reset leaves the line undriven and idle
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // Two banks each: one filled this superframe, the other used now
  always_ff @(posedge i_clk)
  begin
    if (dn_we)
      dn_mem[{s_q.bank, s_q.wr_idx}] <= i_dn_data;
    if (up_we)
      up_mem[{s_q.bank, s_q.slot}] <= up_wdata;
  end

  // Receiver stalls only fill the buffer; the drain waits, but words not drained by the next sync are dropped
  framer_buf #(
    .WIDTH (24),
    .DEPTH (2)
  ) u_up_buf (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_in_valid  (push),
    .o_in_ready  (buf_rdy),
    .i_in_data   (up_rdata),
    .o_out_valid (o_up_valid),
    .i_out_ready (i_up_ready),
    .o_out_data  (o_up_data)
  );

  assign o_bus_tx     = s_q.tx_lvl;
  assign o_bus_oe     = s_q.oe;
  assign o_sync_out   = s_q.sync_out;
  assign o_lock       = s_q.lock;
  assign o_resp       = s_q.resp;
  assign o_resp_ok    = s_q.resp_ok;
  assign o_resp_valid = s_q.resp_stb;
  assign o_dn_ready   = s_q.dn_rdy;

  // A literal cannot be bit-selected, so the checks index this copy of the preamble
  localparam logic [15:0] PRE_BITS = `PRE_PATTERN;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_sync_restart: assert property (sync_edge |=> s_q.phase == framer_pkg::PH_SCF && s_q.pcnt == 10'h000)
    else $error("superframe did not restart on sync");
  a_idle_undriven: assert property (s_q.phase inside {framer_pkg::PH_IDLE, framer_pkg::PH_SRF,
      framer_pkg::PH_UP} |-> !o_bus_oe)
    else $error("bus driven outside downstream period");
  a_scf_then_dn: assert property (rise && !sync_edge && s_q.phase == framer_pkg::PH_SCF && s_q.pcnt == `SCF_LAST
      && s_q.cfg.n_dn != 6'h00 |=> s_q.phase == framer_pkg::PH_DN && s_q.slot == 6'h00)
    else $error("downstream slots do not follow control frame");
  a_pre_bits: assert property (rise && !sync_edge && s_q.phase == framer_pkg::PH_SCF && s_q.pcnt < 10'h010
      |=> o_bus_oe && s_q.cur_bit == PRE_BITS[15 - $past(s_q.pcnt[3:0])])
    else $error("preamble bit wrong");
  a_slot_limit: assert property (s_q.phase == framer_pkg::PH_DN |-> s_q.slot < slot_lim(s_q.cfg.n_dn,
      s_q.cfg.wide) && s_q.sub <= slot_last(s_q.cfg.wide))
    else $error("slot beyond configured limit");
  a_wait_len: assert property (rise && !sync_edge && s_q.phase == framer_pkg::PH_WAIT
      && s_q.pcnt == s_q.cfg.resp_wait |=> s_q.phase == framer_pkg::PH_SRF)
    else $error("response wait length wrong");
  a_sync_fine: assert property (sync_edge && i_sync_dly == 8'h03 ##1 !sync_edge [*4] |=> o_sync_out)
    else $error("sync output delay wrong");
  a_bank_flip: assert property (sync_edge |=> s_q.bank != $past(s_q.bank) && s_q.wr_idx == 6'h00)
    else $error("sample banks not swapped");
  a_srf_then_up: assert property (o_resp_valid && o_resp_ok && s_q.cfg.n_up != 6'h00 && !$past(sync_edge)
      |-> s_q.phase == framer_pkg::PH_UP)
    else $error("upstream slots do not follow response frame");
  a_lock_count: assert property (sync_edge && s_q.bit_cnt == `BITS_PER_FRAME |=> o_lock)
    else $error("lock not reported at 1024 bits");

  c_locked: cover property (sync_edge && s_q.bit_cnt == `BITS_PER_FRAME);
  c_resp_ok: cover property (o_resp_valid && o_resp_ok);
  c_buf_full: cover property (o_up_valid && !i_up_ready && !buf_rdy);
  c_up_slot: cover property (up_we);
endmodule

/* File: tb/chain_model.sv */
// Far side of the framer: host frame sync, bus bit clock and the last subordinate node.
// Assumes the framer samples line and bit clock on its own 40 MHz clock.
`timescale 1ns/1ps
module chain_model #(
  parameter int W     = 24,
  parameter int N_DN  = 2,
  parameter int N_UP  = 3,
  parameter int RWAIT = 10
) (
  input  wire logic              i_run,
  input  wire logic [15:0]       i_pre,
  input  wire framer_pkg::resp_t i_resp,
  input  wire logic              i_tx,
  input  wire logic              i_oe,
  output logic                   o_sync,
  output logic                   o_bit_clk,
  output logic                   o_line,
  output logic [127:0]           o_cap,
  output logic [1:0]             o_oe_seen
);
  // Response bit 0 rides the period whose rise ends the framer's wait
  localparam int R0 = 64 + N_DN * W + RWAIT;
  localparam int NB = 32 + N_UP * W;
  int              rc = 1000;
  logic            sa = 1'b0;
  logic [127:0]    sh = '0;
  logic [NB-1:0]   up_vec;

  // Response frame then three upstream words, MSB first
  assign up_vec = {i_pre, i_resp, 24'h5A0001, 24'h5A0002, 24'h5A0003};

  initial
  begin
    o_sync = 1'b0;
    o_bit_clk = 1'b0;
    o_line = 1'b0;
    o_cap = '0;
    o_oe_seen = '0;
    #7;
    forever #100 o_bit_clk = ~o_bit_clk;
  end

  // Rise: counter restarts at the sync and the line toggles. Fall: sync rises half a bit
  // before bit 0; outside our frames the line keeps toggling so no stale level decodes
  always @(posedge o_bit_clk or negedge o_bit_clk)
  begin
    if (o_bit_clk)
    begin
      rc = i_run ? ((rc == 1023) ? 0 : rc + 1) : 1000;
      o_line = ~o_line;
    end
    else
    begin
      o_sync = i_run && (rc == 1023 || rc < 8);
      if (rc < R0 || rc >= R0 + NB || up_vec[NB - 1 - (rc - R0)])
        o_line = ~o_line;
      #50;
      sa = i_tx;
    end
  end

  // Decode the first 128 bits sent by the framer, away from its toggle instants
  always @(posedge o_bit_clk)
  begin
    #50;
    if (rc >= 1 && rc <= 128)
      sh = {sh[126:0], sa ^ i_tx};
    if (rc == 128)
      o_cap = sh;
    if (rc == 10 || rc == R0 + 4)
      o_oe_seen = {o_oe_seen[0], i_oe};
  end
endmodule

/* File: tb/tb_superframe_framer.sv */
// Self-checking bench for the superframe framer against the chain model.
// Assumes the model supplies host sync, bit clock and the upstream half of each superframe.
`timescale 1ns/1ps
module tb_superframe_framer;
  localparam logic [47:0] CTL = 48'h6B5A1234C3E7;
  localparam logic [15:0] PRE = 16'hF0C5;
  localparam logic [23:0] W0  = 24'hA1B2C3;
  localparam logic [23:0] W1  = 24'h5E6F70;
  logic              i_clk = 1'b0;
  logic              i_rst = 1'b1;
  logic              run = 1'b0;
  logic              dn_valid = 1'b0;
  logic              up_ready = 1'b0;
  logic [7:0]        sync_dly = 8'h00;
  logic [15:0]       pre = PRE;
  logic [23:0]       dn_data = 24'h000000;
  framer_pkg::cfg_t  cfg = {1'b1, 6'h02, 6'h03, 10'h00A};
  framer_pkg::ctl_t  ctl = CTL;
  framer_pkg::resp_t resp_v = 16'h5C3C;
  framer_pkg::resp_t resp;
  logic              sync, bit_clk, line, bus_tx, bus_oe, sync_out, lock, resp_ok, resp_valid;
  logic              dn_ready, up_valid;
  logic [23:0]       up_data;
  logic [127:0]      cap;
  logic [1:0]        oe_seen;
  int                fails = 0;
  int                n_checks = 0;

  superframe_framer i_dut (
    .i_clk        (i_clk),
    .i_rst        (i_rst),
    .i_sync       (sync),
    .i_bit_clk    (bit_clk),
    .i_bus_rx     (line),
    .o_bus_tx     (bus_tx),
    .o_bus_oe     (bus_oe),
    .i_cfg        (cfg),
    .i_ctl        (ctl),
    .i_sync_dly   (sync_dly),
    .o_sync_out   (sync_out),
    .o_lock       (lock),
    .o_resp       (resp),
    .o_resp_ok    (resp_ok),
    .o_resp_valid (resp_valid),
    .i_dn_valid   (dn_valid),
    .i_dn_data    (dn_data),
    .o_dn_ready   (dn_ready),
    .o_up_valid   (up_valid),
    .i_up_ready   (up_ready),
    .o_up_data    (up_data)
  );

  chain_model #(.W(24), .N_DN(2), .N_UP(3), .RWAIT(10)) i_chain (
    .i_run     (run),
    .i_pre     (pre),
    .i_resp    (resp_v),
    .i_tx      (bus_tx),
    .i_oe      (bus_oe),
    .o_sync    (sync),
    .o_bit_clk (bit_clk),
    .o_line    (line),
    .o_cap     (cap),
    .o_oe_seen (oe_seen)
  );

  always #12.5 i_clk = ~i_clk;

  task automatic chk_vec(input string name, input logic [127:0] got, input logic [127:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %s exp=%0h got=%0h", name, exp, got);
    end
  endtask

  task automatic chk_int(input string name, input int got, input int exp);
    n_checks++;
    if (got != exp)
    begin
      fails++;
      $display("[ERR] %s exp=%0d got=%0d", name, exp, got);
    end
  endtask

  // Read just after an edge, so the edge that follows is the one that takes the transfer;
  // edges are counted so a dead handshake is reported instead of hanging
  task automatic wait_hi(ref logic s, input int lim);
    int   k;
    logic seen;
    k = 0;
    seen = 1'b0;
    do
    begin
      #1;
      seen = s;
      @(posedge i_clk);
      k++;
    end
    while (seen !== 1'b1 && k < lim);
    chk_int("handshake", int'(seen === 1'b1), 1);
  endtask

  // Pulse is read off the edge that launches it
  task automatic count_pulse(output int k);
    logic seen;
    k = 0;
    seen = 1'b0;
    while (seen !== 1'b1 && k < 300)
    begin
      @(posedge i_clk);
      #1;
      seen = sync_out;
      k++;
    end
  endtask

  task automatic t_reset_vals();
    @(posedge i_clk);
    #1;
    chk_vec("reset_outputs", {bus_oe, lock, dn_ready, up_valid, resp_valid, sync_out, resp, up_data}, '0);
    $display("test reset values done");
  endtask

  // Two words fill the superframe; a third would be refused
  task automatic t_downstream();
    @(posedge sync);
    repeat (10) @(posedge i_clk);
    chk_vec("dn_ready_open", dn_ready, 1'b1);
    dn_valid <= 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      dn_data <= i ? W1 : W0;
      wait_hi(dn_ready, 100);
    end
    dn_valid <= 1'b0;
    repeat (3) @(posedge i_clk);
    chk_vec("dn_ready_full", dn_ready, 1'b0);
    wait_hi(resp_valid, 9000);
    chk_vec("resp_word", resp, resp_v);
    chk_vec("resp_ok", resp_ok, 1'b1);
    $display("test downstream intake and response done");
  endtask

  // Receiver stalls while the buffer holds, then drains in slot order
  task automatic t_upstream();
    logic [23:0] got;
    @(posedge sync);
    repeat (300) @(posedge i_clk);
    chk_vec("up_stall_valid", up_valid, 1'b1);
    chk_vec("up_stall_data", up_data, 24'h5A0001);
    up_ready <= 1'b1;
    for (int i = 1; i <= 3; i++)
    begin
      #1;
      got = up_data;
      wait_hi(up_valid, 20);
      chk_vec("up_word", got, 24'h5A0000 + i);
    end
    up_ready <= 1'b0;
    repeat (3) @(posedge i_clk);
    chk_vec("up_empty", up_valid, 1'b0);
    $display("test upstream drain done");
  endtask

  task automatic t_frame_out();
    @(posedge sync);
    #1;
    chk_vec("ctl_frame", cap[127:16], {PRE, CTL, W0, W1});
    chk_vec("oe_ctl_resp", oe_seen, 2'b10);
    chk_vec("lock", lock, 1'b1);
    $display("test control frame done");
  endtask

  task automatic t_bad_resp();
    @(posedge i_clk);
    pre <= 16'h0F3A;
    wait_hi(resp_valid, 9000);
    chk_vec("resp_ok_bad", resp_ok, 1'b0);
    pre <= PRE;
    $display("test bad response done");
  endtask

  task automatic t_sync_dly();
    int k0;
    int k1;
    @(posedge sync);
    count_pulse(k0);
    // A step of three also wakes the fixed-delay assertion in the framer
    @(posedge i_clk);
    sync_dly <= 8'h03;
    @(posedge sync);
    count_pulse(k1);
    chk_int("sync_delay_step", k1 - k0, 3);
    $display("test sync delay done");
  endtask

  task automatic test_done();
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // About six superframes of 8192 cycles plus start-up
  initial
  begin
    repeat (50000) @(posedge i_clk);
    fails++;
    $display("[ERR] watchdog exp=finished got=timeout");
    test_done();
  end

  initial
  begin
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    t_reset_vals();
    run <= 1'b1;
    t_downstream();
    t_upstream();
    t_frame_out();
    t_bad_resp();
    t_sync_dly();
    test_done();
  end
endmodule
